//--- hw/flash_array_map.vh
// address map, control register layout and encodings of the flash array controller
`ifndef FLASH_ARRAY_MAP_VH
`define FLASH_ARRAY_MAP_VH
// memory decode windows
`define USER_LO 16'h8000
`define USER_HI 16'hFDFF
`define PROTECT_ADDR 16'hFF80
`define VECT_LO 16'hFFD0
`define VECT_HI 16'hFFFF
`define CTRL_ADDR 16'hFE08
// user array 32256 bytes plus 48 vectors plus protect byte
`define ARRAY_WORDS 32305
`define ARRAY_AW 15
`define VECT_BASE 15'h7E00
`define PROTECT_IDX 15'h7E30
`define USER_BASE 16'h8000
// control register bit positions
`define B_PGM 0
`define B_ERASE 1
`define B_VERIFY 2
`define B_HIGH_VOLTAGE_ENABLE 3
`define B_SIZE_LO 4
`define B_SIZE_HI 5
`define B_DIV_LO 6
`define B_DIV_HI 7
`define CTRL_RESET 8'h00
// erase size codes
`define SIZE_FULL 2'b00
`define SIZE_HALF 2'b01
`define SIZE_EIGHT 2'b10
`define SIZE_ROW 2'b11
// divider codes
`define DIV_ONE 2'b00
`define DIV_FOUR 2'b11
// protect bit lower bounds
`define PROT3_LO 16'hC000
`define PROT2_LO 16'hA000
`define PROT1_LO 16'h9000
`define PROT0_LO 16'h8000
// charge pump needs at least this rate, bus clock rate
`define PUMP_MIN_KHZ 2000
`define BUS_KHZ 10000
`define ERASED_BYTE 8'h00
`define PROG_BYTE_ALL 8'hFF
`define PAGE_LEN 4'h8
`endif

//--- hw/flash_cell_mem.v
// byte-wide storage array modelling the flash cells, registered read data
`timescale 1ns/1ns
`include "flash_array_map.vh"
module flash_cell_mem
(
  input wire clk_sys_in,
  input wire ce_in,
  input wire [`ARRAY_AW-1:0] addr_in,
  input wire rd_in,
  input wire wr_in,
  input wire [7:0] wr_data_in,
  output reg [7:0] rd_data_out
);
  // cell storage, contents have no reset like real flash
  reg [7:0] cells [0:`ARRAY_WORDS-1];
  // one port: write or registered read
  always @(posedge clk_sys_in)
  begin
    if (ce_in)
    begin
      if (wr_in)
        cells[addr_in] <= wr_data_in;
      else if (rd_in)
        rd_data_out <= cells[addr_in];
    end
  end
endmodule

//--- hw/flash_array_control.v
// flash array controller: control register, interlocks, pump divider, array sequencer
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`include "flash_array_map.vh"
// What this block does
// R1 - stores 32256 user, 48 vector, one protect byte
// R2 - erased bit reads 0, programmed 1
// R3 - decodes user, protect and vector ranges
// R4 - pump divider codes divide by 1,2,2,4
// R5 - software matches divider to bus clock
// R6 - no program/erase below 2 MHz pump
// R7 - high voltage bit runs pump and array
// R8 - high voltage needs select and sequence
// R9 - verify set ignored while high voltage
// R10 - high voltage set clears verify select
// R11 - program and erase never both set
// R12 - two block-size bits read/write
// R13 - divider bits always read/write
// R14 - size codes pick full, half, eight rows, row
// R15 - protect read latched, required before high voltage
// R16 - protected range clears program/erase select
// R17 - reset clears control, pump off
module flash_array_control
(
  input wire clk_sys_in,
  input wire rst_n_in,
  input wire ce_in,
  input wire [15:0] addr_in,
  input wire [7:0] wr_data_in,
  input wire wr_in,
  input wire rd_in,
  output reg [7:0] rd_data_out,
  output wire pump_clk_out,
  output wire high_voltage_out,
  output wire pump_fail_out
);
  // control register fields
  reg program_select_r;
  reg erase_select_r;
  reg verify_select_r;
  reg high_voltage_enable_r;
  reg erase_size_hi_r;
  reg erase_size_lo_r;
  reg pump_div_hi_r;
  reg pump_div_lo_r;
  // sequence tracking
  reg protect_seen_r; // protect byte read since select
  reg [7:0] protect_r; // latched protect byte
  reg addr_seen_r; // target address latched
  reg [15:0] target_r; // latched cared address
  reg [2:0] page_idx_r; // page data byte count
  reg [7:0] page_r [0:7]; // page data latches
  reg [1:0] pump_cnt_r; // divider counter
  reg pump_clk_r;
  // array sequencer state: erase walk or page program
  localparam ST_IDLE = 2'b00;
  localparam ST_ERASE = 2'b01;
  localparam ST_PROG = 2'b10;
  reg [1:0] state_r;
  reg [15:0] walk_r; // address walked by the sequencer
  reg [15:0] walk_end_r;
  reg [2:0] pidx_r;
  // read return source
  reg rd_ctrl_r;
  reg rd_mem_r;
  reg [7:0] ctrl_rd_r;
  // protect byte value seen by the latch: last value held for that cell
  reg [7:0] protect_shadow_r;
  wire [7:0] m_q_now = protect_shadow_r;
  integer i;

  // index of a mapped address in the cell memory
  function [`ARRAY_AW-1:0] cell_index;
    input [15:0] a;
    begin
      if (a == `PROTECT_ADDR)
        cell_index = `PROTECT_IDX;
      else if (a >= `VECT_LO)
        cell_index = `VECT_BASE + a[5:0] - 6'd16;
      else
        cell_index = a[14:0];
    end
  endfunction

  // address falls in a decoded flash location
  function is_flash;
    input [15:0] a;
    begin
      is_flash = ((a >= `USER_LO) && (a <= `USER_HI)) || (a == `PROTECT_ADDR) ||
        (a >= `VECT_LO); // R3
    end
  endfunction

  // lowest address covered by the protect byte, FFFF when none
  function [15:0] protect_floor;
    input [7:0] p;
    begin
      if (p[0])
        protect_floor = `PROT0_LO;
      else if (p[1])
        protect_floor = `PROT1_LO;
      else if (p[2])
        protect_floor = `PROT2_LO;
      else if (p[3])
        protect_floor = `PROT3_LO;
      else
        protect_floor = 16'hFFFF;
    end
  endfunction

  // upper end of the region selected by the size code
  function [15:0] region_end;
    input [1:0] sz;
    input [15:0] a;
    begin
      case (sz) // R14
        `SIZE_FULL: region_end = 16'hFFFF;
        `SIZE_HALF: region_end = {a[15:14], 14'h3FFF};
        `SIZE_EIGHT: region_end = {a[15:9], 9'h1FF};
        default: region_end = {a[15:6], 6'h3F};
      endcase
    end
  endfunction

  // lower end of the region selected by the size code
  function [15:0] region_start;
    input [1:0] sz;
    input [15:0] a;
    begin
      case (sz)
        `SIZE_FULL: region_start = `USER_BASE;
        `SIZE_HALF: region_start = {a[15:14], 14'h0000};
        `SIZE_EIGHT: region_start = {a[15:9], 9'h000};
        default: region_start = {a[15:6], 6'h00};
      endcase
    end
  endfunction

  wire [1:0] size_w = {erase_size_hi_r, erase_size_lo_r};
  wire [1:0] div_w = {pump_div_hi_r, pump_div_lo_r};
  wire ctrl_hit = (addr_in == `CTRL_ADDR);
  wire mem_hit = is_flash(addr_in);
  wire [7:0] wd = wr_data_in;
  // pump rate in kHz from bus rate and divider
  wire [13:0] pump_khz = (div_w == `DIV_ONE) ? 14'd10000 :
    (div_w == `DIV_FOUR) ? 14'd2500 : 14'd5000;
  wire pump_ok = (pump_khz >= `PUMP_MIN_KHZ); // R6
  // range of the pending operation crosses protection
  // a program covers its whole page; a blank protect byte locks nothing
  wire [15:0] op_end = program_select_r ? {target_r[15:3], 3'h7} :
    region_end(size_w, target_r);
  wire range_locked = addr_seen_r && (protect_r[3:0] != 4'h0) &&
    (op_end >= protect_floor(protect_r)); // R16
  // sequence complete so high voltage may come on
  wire seq_ok = (program_select_r ^ erase_select_r) && protect_seen_r && addr_seen_r &&
    !range_locked && pump_ok; // R8 R15

  // memory port arbitration: sequencer owns it while in ST_ERASE or ST_PROG
  reg [`ARRAY_AW-1:0] m_addr;
  reg m_rd;
  reg m_wr;
  reg [7:0] m_data;
  wire [7:0] m_q;
  always @*
  begin
    m_addr = cell_index(addr_in);
    m_rd = rd_in && mem_hit;
    m_wr = 1'b0;
    m_data = `ERASED_BYTE;
    if (state_r == ST_ERASE)
    begin
      m_addr = cell_index(walk_r);
      m_rd = 1'b0;
      m_wr = 1'b1; // R2
    end
    else if (state_r == ST_PROG)
    begin
      m_addr = cell_index({target_r[15:3], pidx_r});
      m_rd = 1'b0;
      // page bytes outside the decoded map have no cell behind them
      m_wr = is_flash({target_r[15:3], pidx_r});
      m_data = page_r[pidx_r]; // R2
    end
  end

  flash_cell_mem u_cells
  (
    .clk_sys_in(clk_sys_in),
    .ce_in(ce_in),
    .addr_in(m_addr),
    .rd_in(m_rd),
    .wr_in(m_wr),
    .wr_data_in(m_data),
    .rd_data_out(m_q)
  ); // R1

  // control register with interlocks
  always @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      program_select_r <= 1'b0; // R17
      erase_select_r <= 1'b0;
      verify_select_r <= 1'b0;
      high_voltage_enable_r <= 1'b0;
      erase_size_hi_r <= 1'b0;
      erase_size_lo_r <= 1'b0;
      pump_div_hi_r <= 1'b0;
      pump_div_lo_r <= 1'b0;
    end
    else if (ce_in)
    begin
      if (wr_in && ctrl_hit)
      begin
        pump_div_hi_r <= wd[`B_DIV_HI]; // R13
        pump_div_lo_r <= wd[`B_DIV_LO]; // R4
        erase_size_hi_r <= wd[`B_SIZE_HI]; // R12
        erase_size_lo_r <= wd[`B_SIZE_LO];
        // both requested: neither is taken
        if (!(wd[`B_PGM] && wd[`B_ERASE]))
        begin
          program_select_r <= wd[`B_PGM] && !erase_select_r; // R11
          erase_select_r <= wd[`B_ERASE] && !program_select_r; // R11
        end
        if (wd[`B_HIGH_VOLTAGE_ENABLE] && !high_voltage_enable_r)
        begin
          high_voltage_enable_r <= seq_ok; // R8
          if (seq_ok)
            verify_select_r <= 1'b0; // R10
          else if (!high_voltage_enable_r)
            verify_select_r <= wd[`B_VERIFY];
        end
        else
        begin
          high_voltage_enable_r <= wd[`B_HIGH_VOLTAGE_ENABLE] && high_voltage_enable_r; // R7
          if (!high_voltage_enable_r || !wd[`B_VERIFY])
            verify_select_r <= wd[`B_VERIFY] && !high_voltage_enable_r; // R9
        end
      end
      else if (range_locked && !high_voltage_enable_r)
      begin
        program_select_r <= 1'b0; // R16
        erase_select_r <= 1'b0;
      end
    end
  end

  // protect latch, target address and page data capture
  always @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      protect_seen_r <= 1'b0;
      protect_r <= 8'h00;
      addr_seen_r <= 1'b0;
      target_r <= 16'h0000;
      page_idx_r <= 3'd0;
      for (i = 0; i < 8; i = i + 1)
        page_r[i] <= `ERASED_BYTE;
    end
    else if (ce_in)
    begin
      if (!program_select_r && !erase_select_r)
      begin
        protect_seen_r <= 1'b0;
        addr_seen_r <= 1'b0;
        page_idx_r <= 3'd0;
      end
      else if (rd_in && addr_in == `PROTECT_ADDR && !high_voltage_enable_r)
      begin
        protect_seen_r <= 1'b1; // R15
        protect_r <= m_q_now;
      end
      else if (wr_in && mem_hit && protect_seen_r && !high_voltage_enable_r)
      begin
        addr_seen_r <= 1'b1;
        target_r <= addr_in;
        page_r[addr_in[2:0]] <= wd;
        page_idx_r <= page_idx_r + 3'd1;
      end
    end
  end

  // shadow of the protect cell, follows sequencer writes to it
  always @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      protect_shadow_r <= 8'h00;
    else if (ce_in && m_wr && m_addr == `PROTECT_IDX)
      protect_shadow_r <= m_data;
  end

  // array sequencer: erase walk or page program while high voltage on
  always @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      state_r <= ST_IDLE;
      walk_r <= 16'h0000;
      walk_end_r <= 16'h0000;
      pidx_r <= 3'd0;
    end
    else if (ce_in)
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (wr_in && ctrl_hit && wd[`B_HIGH_VOLTAGE_ENABLE] && !high_voltage_enable_r && seq_ok)
          begin
            walk_r <= region_start(size_w, target_r);
            walk_end_r <= region_end(size_w, target_r);
            pidx_r <= 3'd0;
            state_r <= erase_select_r ? ST_ERASE : ST_PROG;
          end
        end
        ST_ERASE:
        begin
          // skip holes between user space, protect byte and vectors
          if (walk_r == walk_end_r || !high_voltage_enable_r)
            state_r <= ST_IDLE;
          else if (walk_r == `USER_HI)
            walk_r <= `PROTECT_ADDR;
          else if (walk_r == `PROTECT_ADDR)
            walk_r <= (walk_end_r >= `VECT_LO) ? `VECT_LO : walk_end_r;
          else
            walk_r <= walk_r + 16'h0001;
        end
        ST_PROG:
        begin
          if (pidx_r == 3'd7 || !high_voltage_enable_r)
            state_r <= ST_IDLE;
          pidx_r <= pidx_r + 3'd1;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // read data one cycle after the strobe
  always @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      rd_ctrl_r <= 1'b0;
      rd_mem_r <= 1'b0;
      ctrl_rd_r <= `CTRL_RESET;
    end
    else if (ce_in)
    begin
      rd_ctrl_r <= rd_in && ctrl_hit;
      rd_mem_r <= rd_in && mem_hit && (state_r == ST_IDLE);
      ctrl_rd_r <= {pump_div_hi_r, pump_div_lo_r, erase_size_hi_r, erase_size_lo_r,
        high_voltage_enable_r, verify_select_r, erase_select_r, program_select_r};
    end
  end
  always @*
  begin
    if (rd_ctrl_r)
      rd_data_out = ctrl_rd_r;
    else if (rd_mem_r)
      rd_data_out = m_q;
    else
      rd_data_out = 8'h00;
  end

  // pump clock shown at half the pump rate, a flop cannot toggle faster; codes keep 1:2:4
  always @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      pump_cnt_r <= 2'd0;
      pump_clk_r <= 1'b0;
    end
    else if (ce_in)
    begin
      if (!high_voltage_enable_r)
      begin
        pump_cnt_r <= 2'd0; // R7
        pump_clk_r <= 1'b0;
      end
      else if (div_w == `DIV_ONE)
        pump_clk_r <= ~pump_clk_r; // R4
      else
      begin
        pump_cnt_r <= pump_cnt_r + 2'd1;
        if (pump_cnt_r[0] && (div_w != `DIV_FOUR || pump_cnt_r[1]))
          pump_clk_r <= ~pump_clk_r; // R4
      end
    end
  end

  assign pump_clk_out = pump_clk_r;
  assign high_voltage_out = high_voltage_enable_r; // R7
  assign pump_fail_out = !pump_ok; // R5
endmodule

//--- sim/flash_array_control_chk.sv
// port checker for the flash array controller
`timescale 1ns/1ns
`include "flash_array_map.vh"
module flash_array_control_chk
(
  input wire clk_sys_in,
  input wire rst_n_in,
  input wire ce_in,
  input wire [15:0] addr_in,
  input wire [7:0] wr_data_in,
  input wire wr_in,
  input wire rd_in,
  input wire [7:0] rd_data_out,
  input wire pump_clk_out,
  input wire high_voltage_out,
  input wire pump_fail_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // control register was read last cycle, so read data shows it now
  logic ctl_rd_r;
  always @(posedge clk_sys_in)
    if (!rst_n_in)
      ctl_rd_r <= 1'b0;
    else if (ce_in)
      ctl_rd_r <= rd_in && addr_in == `CTRL_ADDR;
  AST_RD_IDLE: assert property (!$past(rd_in) |-> rd_data_out == 8'h00)
    else $error("read data not zero outside a read");
  AST_HV_READ: assert property (ctl_rd_r |-> rd_data_out[3] == high_voltage_out)
    else $error("high voltage pin differs from its bit");
  AST_VERIFY_OFF: assert property (ctl_rd_r && rd_data_out[3] |-> !rd_data_out[2])
    else $error("verify set beside high voltage");
  AST_ONE_SELECT: assert property (ctl_rd_r |-> !(rd_data_out[0] && rd_data_out[1]))
    else $error("program and erase both set");
  AST_HV_SELECT: assert property (ctl_rd_r && rd_data_out[3] |-> ^rd_data_out[1:0])
    else $error("high voltage without one select");
  AST_HV_CAUSE: assert property ($rose(high_voltage_out) |->
    $past(wr_in && addr_in == `CTRL_ADDR && wr_data_in[3]))
    else $error("high voltage rose without a write");
  AST_PUMP_OFF: assert property (!high_voltage_out [*2] |-> !pump_clk_out)
    else $error("pump clock runs with high voltage off");
  AST_NO_FAIL: assert property (!pump_fail_out)
    else $error("pump rate flagged too low");
  AST_FREEZE: assert property (!ce_in |=> $stable(high_voltage_out) && $stable(pump_clk_out))
    else $error("state moved while clock enable low");
  AST_RESET: assert property (!$past(rst_n_in) |-> !high_voltage_out && !pump_clk_out)
    else $error("outputs not idle after reset");
  // main scenarios reached
  COV_HV: cover property ($rose(high_voltage_out));
  COV_CTL_RD: cover property (ctl_rd_r);
  COV_STALL: cover property (!ce_in && high_voltage_out);
endmodule
bind flash_array_control flash_array_control_chk i_chk
(
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .addr_in(addr_in),
  .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
  .pump_clk_out(pump_clk_out), .high_voltage_out(high_voltage_out),
  .pump_fail_out(pump_fail_out)
);

//--- sim/flash_array_control_tb.sv
// self-checking bench for the flash array controller
`timescale 1ns/1ns
`include "flash_array_map.vh"
module flash_array_control_tb;
  localparam [15:0] ctl = `CTRL_ADDR;
  localparam [15:0] prot = `PROTECT_ADDR;
  reg clk_sys_in = 1'b0;
  reg rst_n_in = 1'b0;
  reg ce_in = 1'b1;
  reg [15:0] addr_in = 16'h0000;
  reg [7:0] wr_data_in = 8'h00;
  reg wr_in = 1'b0;
  reg rd_in = 1'b0;
  wire [7:0] rd_data_out;
  wire pump_clk_out;
  wire high_voltage_out;
  wire pump_fail_out;
  integer fails = 0;
  integer n_checks = 0;
  integer cycles = 0;
  integer i;
  // 10 MHz bus clock
  always #50 clk_sys_in = ~clk_sys_in;
  flash_array_control i_dut
  (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
    .pump_clk_out(pump_clk_out), .high_voltage_out(high_voltage_out),
    .pump_fail_out(pump_fail_out)
  );
  // verdict, reached from the main flow or the hang guard
  task test_done;
    if (fails == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // compare one byte, four-state
  task chk(input string what, input [7:0] exp, input [7:0] got);
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("FAIL %s exp %h got %h", what, exp, got);
    end
  endtask
  // one-cycle write strobe
  task wr(input [15:0] a, input [7:0] d);
    @(posedge clk_sys_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
  endtask
  // one-cycle read strobe; data stand only in the following cycle
  task rd(input [15:0] a, input [7:0] exp, input bit c = 1'b1);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1;
    if (c)
      chk($sformatf("rd %h", a), exp, rd_data_out);
  endtask
  // high voltage pin level
  task hv(input bit e);
    #1;
    chk("hv", {7'h00, e}, {7'h00, high_voltage_out});
  endtask
  // count pump clock changes over n cycles
  task pump(input integer n, input [7:0] exp);
    reg last;
    integer tog;
    tog = 0;
    last = pump_clk_out;
    repeat (n)
    begin
      @(posedge clk_sys_in);
      #1;
      if (pump_clk_out !== last)
        tog = tog + 1;
      last = pump_clk_out;
    end
    chk("pump edges", exp, tog[7:0]);
  endtask
  // hang guard, far above the few hundred cycles the flow needs
  always @(posedge clk_sys_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      fails = fails + 1;
      test_done;
    end
  end
  initial
  begin
    repeat (10) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    rd(ctl, `CTRL_RESET);
    hv(1'b0);
    wr(ctl, 8'hF0);
    rd(ctl, 8'hF0);
    wr(ctl, 8'h00);
    rd(ctl, 8'h00);
    wr(ctl, 8'h03);
    rd(ctl, 8'h00);
    wr(ctl, 8'h01);
    wr(ctl, 8'h03);
    rd(ctl, 8'h01);
    wr(ctl, 8'h09);
    hv(1'b0);
    rd(16'h7000, 8'h00);
    // erase one row at divide by four; program select left over must go first
    wr(ctl, 8'h00);
    wr(ctl, 8'hF2);
    rd(prot, 8'h00, 1'b0);
    wr(16'h8000, 8'h00);
    wr(ctl, 8'hFA);
    hv(1'b1);
    pump(16, 8'd4);
    chk("pump fail", 8'h00, {7'h00, pump_fail_out});
    repeat (100) @(posedge clk_sys_in);
    wr(ctl, 8'hF2);
    wr(ctl, 8'h00);
    for (i = 0; i < 8; i = i + 1)
      rd(16'h8000 + i, `ERASED_BYTE);
    // program one page at divide by one, with a stall
    wr(ctl, 8'h01);
    rd(prot, 8'h00, 1'b0);
    for (i = 0; i < 8; i = i + 1)
      wr(16'h8000 + i, 8'hA0 + i);
    wr(ctl, 8'h0D);
    rd(ctl, 8'h09);
    wr(ctl, 8'h0D);
    rd(ctl, 8'h09);
    pump(16, 8'd16);
    ce_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    ce_in <= 1'b1;
    repeat (20) @(posedge clk_sys_in);
    wr(ctl, 8'h01);
    hv(1'b0);
    wr(ctl, 8'h05);
    rd(ctl, 8'h05);
    wr(ctl, 8'h04);
    wr(ctl, 8'h00);
    for (i = 0; i < 8; i = i + 1)
      rd(16'h8000 + i, 8'hA0 + i);
    // lock the whole array through the protect byte
    wr(ctl, 8'h01);
    rd(prot, 8'h00, 1'b0);
    wr(prot, 8'h01);
    wr(ctl, 8'h49);
    pump(16, 8'd8);
    repeat (20) @(posedge clk_sys_in);
    wr(ctl, 8'h01);
    wr(ctl, 8'h00);
    rd(prot, 8'h01);
    wr(ctl, 8'h01);
    rd(prot, 8'h01);
    wr(16'h8000, 8'h55);
    rd(ctl, 8'h00);
    test_done;
  end
endmodule
